// ---- hw/rsic_pkg.sv ----
package rsic_pkg;

  // ************************************************************
  // Timing, in microseconds of the divided tick.
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int TICK_CYC = CLK_MHZ;
  localparam logic [15:0] POR_US = 16'd500;
  localparam logic [15:0] XTAL_FIRST_US = 16'd2500;
  localparam logic [15:0] CAL_US = 16'd6500;
  localparam logic [15:0] PLL_US = 16'd300;
  localparam logic [15:0] RXON_US = 16'd20;
  localparam logic [15:0] XTAL_SETTLE_RST = 16'd2500;
  localparam logic [9:0] MS_US = 10'd1000;

  // ************************************************************
  // Register byte offsets and reset values.
  // ************************************************************
  localparam logic [7:0] OFS_STATE_CMD = 8'h00;
  localparam logic [7:0] OFS_RESTART = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h14;
  localparam logic [7:0] OFS_IRQ_SEL = 8'h18;
  localparam logic [7:0] OFS_GPO_SEL = 8'h1C;
  localparam logic [7:0] OFS_XTAL_SETTLE = 8'h20;
  localparam logic [7:0] OFS_SLEEP_TMR = 8'h24;
  localparam logic [7:0] OFS_NVM_BASE = 8'h80;
  localparam int NVM_BYTES = 32;
  localparam logic [7:0] IRQ_SEL_RST = 8'h00;
  localparam logic [7:0] GPO_SEL_RST = 8'h00;

  // ************************************************************
  // State switch commands and interrupt source positions.
  // ************************************************************
  localparam logic [4:0] CMD_SLEEP = 5'h01;
  localparam logic [4:0] CMD_STBY = 5'h02;
  localparam logic [4:0] CMD_TUNE = 5'h04;
  localparam logic [4:0] CMD_RX = 5'h08;
  localparam logic [4:0] CMD_NVM = 5'h10;
  localparam int SRC_STICKY = 8;
  localparam int SRC_AUTO = 6;
  localparam int SRC_SLEEP_EXPIRY = 6;

  // GPO select codes, two bits per pin.
  localparam logic [1:0] GPO_DEF = 2'h0;
  localparam logic [1:0] GPO_IRQ_A = 2'h1;
  localparam logic [1:0] GPO_IRQ_B = 2'h2;
  localparam logic [1:0] GPO_ALT = 2'h3;

  typedef enum logic [3:0] {
    ST_POR = 4'h0,
    ST_XTAL = 4'h1,
    ST_CAL = 4'h2,
    ST_SLEEP = 4'h3,
    ST_STBY = 4'h4,
    ST_TUNE = 4'h5,
    ST_RX = 4'h6,
    ST_NVM = 4'h7
  } rsic_state_type;

endpackage : rsic_pkg

// ---- hw/rsic_top.sv ----
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Hold internal reset 0.5 ms after power, then start the crystal.
// - First power-up waits a fixed 2.5 ms for crystal settling.
// - Calibrate 6.5 ms once per power cycle or soft reset.
// - After calibration enter sleep; then software switches state via switch field.
// - Six states: power-up, sleep, standby, tune, receive, nonvolatile access.
// - Each state powers its own set of blocks.
// - Nonvolatile access is entered only from sleep.
// - Soft reset returns to power-up and recalibrates.
// - Power-up sequence ends in sleep without any command.
// - Sleep keeps registers reachable, crystal off, FIFO inaccessible.
// - Sleep timer expiry moves the device to standby.
// - Sleep to standby takes the configured crystal settling time.
// - FIFO contents are kept in standby and tune.
// - Standby to tune takes 300 us, tune to receive 20 us.
// - Nonvolatile state exposes a separate 32-byte user area.
// - Each general output picks its source from its own option list.
// - Eight sticky interrupt sources held until the controller clears them.
// - Six self-clearing sources follow live conditions.
// - Both interrupt lines active high, each picked by a 4-bit select.
// - Sticky sources assert only when enabled; write-one clears, bit self-clears.
// - In receive, demodulated data goes to the configured data output.
module rsic_top #(
  parameter int TICK_CYC = rsic_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources from the data path
  input wire logic [7:0] event_src,
  input wire logic [5:0] live_src,
  // Demodulator pins, outside this clock domain
  input wire logic demod_data,
  input wire logic recovered_clock,
  // Power enables
  output logic pwr_xtal,
  output logic pwr_fifo,
  output logic pwr_pll,
  output logic pwr_rx,
  output logic fifo_access_en,
  // General outputs
  output logic general_out_one,
  output logic general_out_two,
  output logic general_out_three,
  output logic general_out_four
);

  // ************************************************************
  // Microsecond tick and millisecond tick.
  // ************************************************************
  logic [15:0] tick_cnt;
  logic tick_us;
  logic [9:0] ms_cnt;
  logic tick_ms;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= 16'h0000;
      tick_us <= 1'b0;
    end else if (tick_cnt == 16'(TICK_CYC - 1)) begin
      tick_cnt <= 16'h0000;
      tick_us <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick_us <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ms_cnt <= 10'h000;
      tick_ms <= 1'b0;
    end else begin
      tick_ms <= 1'b0;
      if (tick_us) begin
        if (ms_cnt == rsic_pkg::MS_US - 10'h001) begin
          ms_cnt <= 10'h000;
          tick_ms <= 1'b1;
        end else begin
          ms_cnt <= ms_cnt + 10'h001;
        end
      end
    end
  end

  // ************************************************************
  // Register file.
  // ************************************************************
  logic [7:0] irq_en;
  logic [7:0] irq_sel;
  logic [7:0] gpo_sel;
  logic [15:0] xtal_settle;
  logic [15:0] sleep_period;
  logic sleep_tmr_en;
  logic [7:0] nvm_mem [rsic_pkg::NVM_BYTES];
  logic [7:0] sticky;
  rsic_pkg::rsic_state_type cur;
  rsic_pkg::rsic_state_type goal;
  logic settling;

  logic wr_en;
  logic setup;
  logic nvm_hit;
  logic mapped;
  assign wr_en = psel && penable && pwrite && !pslverr;
  assign setup = psel && !penable;
  assign nvm_hit = paddr[7];
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b0;
    unique case (paddr)
      rsic_pkg::OFS_STATE_CMD, rsic_pkg::OFS_RESTART, rsic_pkg::OFS_STATUS,
      rsic_pkg::OFS_IRQ_EN, rsic_pkg::OFS_IRQ_CLR, rsic_pkg::OFS_IRQ_FLAGS,
      rsic_pkg::OFS_IRQ_SEL, rsic_pkg::OFS_GPO_SEL, rsic_pkg::OFS_XTAL_SETTLE,
      rsic_pkg::OFS_SLEEP_TMR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // The user area answers with an error outside its state.
  assign pslverr = psel && penable && (nvm_hit ? (cur != rsic_pkg::ST_NVM) || (paddr[1:0] != 2'h0)
                                               : !mapped);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_en <= 8'h00;
      irq_sel <= rsic_pkg::IRQ_SEL_RST;
      gpo_sel <= rsic_pkg::GPO_SEL_RST;
      xtal_settle <= rsic_pkg::XTAL_SETTLE_RST;
      sleep_period <= 16'h0000;
      sleep_tmr_en <= 1'b0;
    end else if (wr_en) begin
      unique case (paddr)
        rsic_pkg::OFS_IRQ_EN: irq_en <= pwdata[7:0];
        rsic_pkg::OFS_IRQ_SEL: irq_sel <= pwdata[7:0];
        rsic_pkg::OFS_GPO_SEL: gpo_sel <= pwdata[7:0];
        rsic_pkg::OFS_XTAL_SETTLE: xtal_settle <= pwdata[15:0];
        rsic_pkg::OFS_SLEEP_TMR: begin
          sleep_period <= pwdata[15:0];
          sleep_tmr_en <= pwdata[16];
        end
        default: ;
      endcase
    end
  end

  // The user area is kept apart from the configuration registers.
  always_ff @(posedge clk) begin
    if (wr_en && nvm_hit) begin
      nvm_mem[paddr[6:2]] <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      if (nvm_hit) begin
        prdata <= {24'h00_0000, nvm_mem[paddr[6:2]]};
      end else begin
        unique case (paddr)
          rsic_pkg::OFS_STATE_CMD: prdata <= {28'h000_0000, goal};
          rsic_pkg::OFS_STATUS: prdata <= {22'h00_0000, fifo_access_en, pwr_rx, pwr_pll,
                                           pwr_fifo, pwr_xtal, settling, cur};
          rsic_pkg::OFS_IRQ_EN: prdata <= {24'h00_0000, irq_en};
          rsic_pkg::OFS_IRQ_FLAGS: prdata <= {18'h0_0000, live_src, sticky};
          rsic_pkg::OFS_IRQ_SEL: prdata <= {24'h00_0000, irq_sel};
          rsic_pkg::OFS_GPO_SEL: prdata <= {24'h00_0000, gpo_sel};
          rsic_pkg::OFS_XTAL_SETTLE: prdata <= {16'h0000, xtal_settle};
          rsic_pkg::OFS_SLEEP_TMR: prdata <= {15'h0000, sleep_tmr_en, sleep_period};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ************************************************************
  // State sequencer.
  // ************************************************************
  logic in_pup;
  logic cmd_wr;
  logic restart_wr;
  logic sleep_expire;
  logic [15:0] seq_cnt;
  logic [15:0] step_us;
  rsic_pkg::rsic_state_type next_cur;
  rsic_pkg::rsic_state_type step_to;

  assign in_pup = (cur == rsic_pkg::ST_POR) || (cur == rsic_pkg::ST_XTAL) ||
                  (cur == rsic_pkg::ST_CAL);
  assign cmd_wr = wr_en && (paddr == rsic_pkg::OFS_STATE_CMD) && !in_pup;
  assign restart_wr = wr_en && (paddr == rsic_pkg::OFS_RESTART) && pwdata[0];

  // Upward moves step one level at a time so each settle time is honoured.
  always_comb begin
    step_to = cur;
    step_us = 16'h0000;
    unique case (cur)
      rsic_pkg::ST_POR: begin
        step_to = rsic_pkg::ST_XTAL;
        step_us = rsic_pkg::POR_US;
      end
      rsic_pkg::ST_XTAL: begin
        step_to = rsic_pkg::ST_CAL;
        step_us = rsic_pkg::XTAL_FIRST_US;
      end
      rsic_pkg::ST_CAL: begin
        step_to = rsic_pkg::ST_SLEEP;
        step_us = rsic_pkg::CAL_US;
      end
      rsic_pkg::ST_SLEEP: begin
        step_to = rsic_pkg::ST_STBY;
        step_us = xtal_settle;
      end
      rsic_pkg::ST_STBY: begin
        step_to = rsic_pkg::ST_TUNE;
        step_us = rsic_pkg::PLL_US;
      end
      rsic_pkg::ST_TUNE: begin
        step_to = rsic_pkg::ST_RX;
        step_us = rsic_pkg::RXON_US;
      end
      rsic_pkg::ST_RX, rsic_pkg::ST_NVM: begin
        step_to = cur;
        step_us = 16'h0000;
      end
    endcase
  end

  assign settling = in_pup || ((goal > cur) && (goal != rsic_pkg::ST_NVM) &&
                    (cur != rsic_pkg::ST_NVM));

  always_comb begin
    next_cur = cur;
    if (in_pup || settling) begin
      if (seq_cnt >= step_us) begin
        next_cur = step_to;
      end
    end else if (goal != cur) begin
      // Downward moves and leaving the user area are immediate.
      next_cur = (cur == rsic_pkg::ST_NVM) ? rsic_pkg::ST_SLEEP : goal;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur <= rsic_pkg::ST_POR;
      seq_cnt <= 16'h0000;
    end else if (restart_wr) begin
      cur <= rsic_pkg::ST_XTAL;
      seq_cnt <= 16'h0000;
    end else if (next_cur != cur) begin
      cur <= next_cur;
      seq_cnt <= 16'h0000;
    end else if (!settling) begin
      // Time spent idle must not count towards the next settle time.
      seq_cnt <= 16'h0000;
    end else if (tick_us && (seq_cnt != 16'hFFFF)) begin
      seq_cnt <= seq_cnt + 16'h0001;
    end
  end

  // Goal tracks the last accepted command.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      goal <= rsic_pkg::ST_SLEEP;
    end else if (restart_wr || in_pup) begin
      goal <= rsic_pkg::ST_SLEEP;
    end else if (cmd_wr) begin
      unique case (pwdata[4:0])
        rsic_pkg::CMD_SLEEP: goal <= rsic_pkg::ST_SLEEP;
        rsic_pkg::CMD_STBY: goal <= rsic_pkg::ST_STBY;
        rsic_pkg::CMD_TUNE: goal <= rsic_pkg::ST_TUNE;
        rsic_pkg::CMD_RX: goal <= rsic_pkg::ST_RX;
        rsic_pkg::CMD_NVM: begin
          if (cur == rsic_pkg::ST_SLEEP && goal == rsic_pkg::ST_SLEEP) begin
            goal <= rsic_pkg::ST_NVM;
          end
        end
        default: ;
      endcase
    end else if (sleep_expire && goal == rsic_pkg::ST_SLEEP) begin
      goal <= rsic_pkg::ST_STBY;
    end
  end

  // ************************************************************
  // Sleep timer, counted in milliseconds while asleep.
  // ************************************************************
  logic [15:0] sleep_cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleep_cnt <= 16'h0000;
      sleep_expire <= 1'b0;
    end else begin
      sleep_expire <= 1'b0;
      if (!sleep_tmr_en || cur != rsic_pkg::ST_SLEEP || goal != rsic_pkg::ST_SLEEP) begin
        sleep_cnt <= 16'h0000;
      end else if (tick_ms) begin
        if (sleep_cnt + 16'h0001 >= sleep_period) begin
          sleep_cnt <= 16'h0000;
          sleep_expire <= 1'b1;
        end else begin
          sleep_cnt <= sleep_cnt + 16'h0001;
        end
      end
    end
  end

  // ************************************************************
  // Power enables per state.
  // ************************************************************
  assign pwr_xtal = (cur != rsic_pkg::ST_POR) && (cur != rsic_pkg::ST_SLEEP);
  assign pwr_fifo = (cur == rsic_pkg::ST_STBY) || (cur == rsic_pkg::ST_TUNE) ||
                    (cur == rsic_pkg::ST_RX);
  assign pwr_pll = (cur == rsic_pkg::ST_TUNE) || (cur == rsic_pkg::ST_RX);
  assign pwr_rx = (cur == rsic_pkg::ST_RX);
  assign fifo_access_en = pwr_fifo;

  // ************************************************************
  // Interrupt flags and line selection.
  // ************************************************************
  logic [7:0] ev_in;
  logic [7:0] ev_prev;
  logic [7:0] ev_rise;
  logic [7:0] clr_bits;
  logic [13:0] all_src;
  logic irq_line_a;
  logic irq_line_b;

  assign ev_in = event_src | (8'(sleep_expire) << rsic_pkg::SRC_SLEEP_EXPIRY);
  assign ev_rise = ev_in & ~ev_prev & irq_en;
  // The clear bit is a strobe, so it reads back as zero by itself.
  assign clr_bits = (wr_en && paddr == rsic_pkg::OFS_IRQ_CLR) ? pwdata[7:0] : 8'h00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev_prev <= 8'h00;
      sticky <= 8'h00;
    end else begin
      ev_prev <= ev_in;
      sticky <= ((sticky & ~clr_bits) | ev_rise) & irq_en;
    end
  end

  assign all_src = {live_src, sticky};
  assign irq_line_a = (irq_sel[3:0] < 4'd14) ? all_src[irq_sel[3:0]] : 1'b0;
  assign irq_line_b = (irq_sel[7:4] < 4'd14) ? all_src[irq_sel[7:4]] : 1'b0;

  // ************************************************************
  // Demodulator pin synchronisers.
  // ************************************************************
  logic [1:0] data_sync;
  logic [1:0] rclk_sync;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_sync <= 2'h0;
      rclk_sync <= 2'h0;
    end else begin
      data_sync <= {data_sync[0], demod_data};
      rclk_sync <= {rclk_sync[0], recovered_clock};
    end
  end

  logic data_out;
  logic recovered_clock_out;
  logic clock_out;
  logic reset_out_n;
  assign data_out = pwr_rx & data_sync[1];
  assign recovered_clock_out = pwr_rx & rclk_sync[1];
  assign reset_out_n = (cur != rsic_pkg::ST_POR);

  // Clock out toggles on the microsecond tick while the crystal runs.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clock_out <= 1'b0;
    end else if (!pwr_xtal) begin
      clock_out <= 1'b0;
    end else if (tick_us) begin
      clock_out <= ~clock_out;
    end
  end

  // ************************************************************
  // General output selection, registered.
  // ************************************************************
  function automatic logic pick(input logic [1:0] s, input logic d, input logic alt,
                                input logic a, input logic b);
    logic r;
    r = d;
    unique case (s)
      rsic_pkg::GPO_DEF: r = d;
      rsic_pkg::GPO_IRQ_A: r = a;
      rsic_pkg::GPO_IRQ_B: r = b;
      rsic_pkg::GPO_ALT: r = alt;
    endcase
    return r;
  endfunction : pick

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      general_out_one <= 1'b0;
      general_out_two <= 1'b0;
      general_out_three <= 1'b0;
      general_out_four <= 1'b0;
    end else begin
      general_out_one <= pick(gpo_sel[1:0], reset_out_n, data_out, irq_line_a,
                              irq_line_b);
      general_out_two <= pick(gpo_sel[3:2], irq_line_a, recovered_clock_out, irq_line_a,
                              irq_line_b);
      general_out_three <= pick(gpo_sel[5:4], clock_out, data_out, irq_line_a,
                                irq_line_b);
      general_out_four <= pick(gpo_sel[7:6], data_out, recovered_clock_out, irq_line_a,
                               irq_line_b);
    end
  end

endmodule : rsic_top

// ---- tb/rsic_chk.sv ----
`timescale 1ns/1ps
module rsic_chk #(
  parameter int TICK_CYC = rsic_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Power enables
  input wire logic pwr_xtal,
  input wire logic pwr_fifo,
  input wire logic pwr_pll,
  input wire logic pwr_rx,
  input wire logic fifo_access_en
);
  // *****************************************
  // Dwell counters for the timed transitions.
  // *****************************************
  logic [31:0] up_cnt;
  logic [31:0] stby_cnt;
  logic [31:0] tune_cnt;
  logic wr;
  logic [4:0] cmd;
  assign wr = psel && penable && pwrite && paddr == rsic_pkg::OFS_STATE_CMD;
  assign cmd = pwdata[4:0];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) up_cnt <= '0;
    else if (up_cnt != '1) up_cnt <= up_cnt + 32'h1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) stby_cnt <= '0;
    else stby_cnt <= (pwr_fifo && !pwr_pll) ? stby_cnt + 32'h1 : '0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) tune_cnt <= '0;
    else tune_cnt <= (pwr_pll && !pwr_rx) ? tune_cnt + 32'h1 : '0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // One tick of slack is allowed on every timed step.
  property p_xtal_late; pwr_xtal |-> up_cnt >= 499 * TICK_CYC; endproperty
  property p_fifo_late; pwr_fifo |-> up_cnt >= 9499 * TICK_CYC; endproperty
  property p_nested;
    (pwr_fifo || pwr_pll || pwr_rx) |-> pwr_xtal && (!pwr_rx || pwr_pll) && (!pwr_pll || pwr_fifo);
  endproperty
  property p_tune_wait; $rose(pwr_pll) |-> stby_cnt >= 299 * TICK_CYC; endproperty
  property p_rx_wait; $rose(pwr_rx) |-> tune_cnt >= 19 * TICK_CYC; endproperty
  property p_down; wr && cmd == rsic_pkg::CMD_SLEEP && pwr_fifo |-> ##[1:2] !pwr_xtal; endproperty
  property p_nvm_refused; wr && cmd == rsic_pkg::CMD_NVM && pwr_fifo |=> pwr_fifo [*2]; endproperty
  property p_fifo_gate; fifo_access_en == pwr_fifo; endproperty
  property p_clr_zero;
    psel && penable && !pwrite && paddr == rsic_pkg::OFS_IRQ_CLR |-> prdata == 32'h0;
  endproperty
  a_xtal_late: assert property (p_xtal_late) else $error("crystal on too early");
  a_fifo_late: assert property (p_fifo_late) else $error("power-up too short");
  a_nested: assert property (p_nested) else $error("power enables out of order");
  a_tune_wait: assert property (p_tune_wait) else $error("tune too early");
  a_rx_wait: assert property (p_rx_wait) else $error("receive too early");
  a_down: assert property (p_down) else $error("sleep not immediate");
  a_nvm_refused: assert property (p_nvm_refused) else $error("user area entered");
  a_fifo_gate: assert property (p_fifo_gate) else $error("fifo access wrong");
  a_clr_zero: assert property (p_clr_zero) else $error("clear reads nonzero");
  c_rx: cover property ($rose(pwr_rx));
  c_err: cover property (pslverr);
  c_down: cover property ($fell(pwr_xtal));
endmodule : rsic_chk

bind rsic_top rsic_chk #(.TICK_CYC(TICK_CYC)) u_rsic_chk (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .pwr_xtal(pwr_xtal), .pwr_fifo(pwr_fifo), .pwr_pll(pwr_pll), .pwr_rx(pwr_rx),
  .fifo_access_en(fifo_access_en)
);

// ---- tb/rsic_demod_model.sv ----
`timescale 1ns/1ps
module rsic_demod_model (
  // Frame control
  input wire logic frame_on,
  // Demodulator pins
  output logic demod_data,
  output logic recovered_clock
);
  // ***************************************************
  // Recovered clock of 160 ns, only inside a frame.
  // ***************************************************
  logic [7:0] pat;
  initial begin
    pat = 8'hB4;
    demod_data = 1'b0;
    recovered_clock = 1'b0;
    // The odd offset keeps the link clock out of phase with the block clock.
    #3.3;
    forever begin
      #80;
      if (frame_on) begin
        recovered_clock = !recovered_clock;
        if (!recovered_clock) begin
          pat = {pat[6:0], pat[7]};
          demod_data = pat[7];
        end
      end else begin
        // Between frames the data line is not to be trusted, so it keeps moving.
        recovered_clock = 1'b0;
        demod_data = !demod_data;
      end
    end
  end
endmodule : rsic_demod_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb;
  // *****************************************
  // Signals and design.
  // *****************************************
  localparam int T = 4;
  localparam int UP_US [6] = '{490, 510, 2990, 3010, 9490, 9510};
  localparam logic [31:0] UP_ST [6] = '{32'h0, 32'h1, 32'h1, 32'h2, 32'h2, 32'h3};
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, frame_on;
  logic [7:0] paddr, event_src;
  logic [31:0] pwdata, prdata, seed;
  logic [5:0] live_src;
  logic demod_data, recovered_clock, pwr_xtal, pwr_fifo, pwr_pll, pwr_rx, fifo_access_en;
  logic general_out_one, general_out_two, general_out_three, general_out_four;
  logic [64:0] exp_q[$];
  logic [64:0] ent;
  int num_errors, num_checks, cyc;
  rsic_top #(.TICK_CYC(T)) u_rsic_top (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_src(event_src), .live_src(live_src), .demod_data(demod_data),
    .recovered_clock(recovered_clock), .pwr_xtal(pwr_xtal), .pwr_fifo(pwr_fifo),
    .pwr_pll(pwr_pll), .pwr_rx(pwr_rx), .fifo_access_en(fifo_access_en),
    .general_out_one(general_out_one), .general_out_two(general_out_two),
    .general_out_three(general_out_three), .general_out_four(general_out_four));
  rsic_demod_model u_rsic_demod_model (.frame_on(frame_on), .demod_data(demod_data),
    .recovered_clock(recovered_clock));
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= resetn ? cyc + 1 : 0;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [7:0] ev);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1; event_src <= ev;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, event_src);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic e,
                    input logic [31:0] v);
    exp_q.push_back({m, e, v & m});
    apb(1'b0, a, 32'h0, event_src);
  endtask : rd
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready) begin
      ent = exp_q.pop_front();
      `CHK({pslverr, prdata & ent[64:33]}, ent[32:0])
    end
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // The whole run is about 80k cycles, so this limit only trips on a hang.
  initial begin
    #800000;
    num_errors++;
    end_of_test();
  end
  // *****************************************
  // Main sequence.
  // *****************************************
  initial begin
    clk = 1'b0; resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; event_src = 8'h00; live_src = 6'h00;
    frame_on = 1'b0; seed = 32'h0000CCAD; num_errors = 0; num_checks = 0; cyc = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      while (cyc < UP_US[i] * T) @(posedge clk);
      rd(rsic_pkg::OFS_STATUS, 32'hF, 1'b0, UP_ST[i]);
    end
    wr(rsic_pkg::OFS_XTAL_SETTLE, 32'hA);
    rd(rsic_pkg::OFS_XTAL_SETTLE, 32'hFFFF, 1'b0, 32'hA);
    rd(8'h40, 32'h0, 1'b1, 32'h0);
    rd(rsic_pkg::OFS_IRQ_CLR, 32'hFFFFFFFF, 1'b0, 32'h0);
    rd(rsic_pkg::OFS_NVM_BASE, 32'h0, 1'b1, 32'h0);
    wr(rsic_pkg::OFS_STATE_CMD, 32'(rsic_pkg::CMD_NVM));
    rd(rsic_pkg::OFS_STATUS, 32'h3EF, 1'b0, 32'h27);
    for (int k = 0; k < 32; k += 31) begin
      seed = lfsr(seed);
      wr(rsic_pkg::OFS_NVM_BASE + 8'(4 * k), seed);
      rd(rsic_pkg::OFS_NVM_BASE + 8'(4 * k), 32'hFF, 1'b0, seed);
    end
    wr(rsic_pkg::OFS_STATE_CMD, 32'(rsic_pkg::CMD_SLEEP));
    rd(rsic_pkg::OFS_STATUS, 32'h3EF, 1'b0, 32'h3);
    wr(rsic_pkg::OFS_STATE_CMD, 32'(rsic_pkg::CMD_STBY));
    rd(rsic_pkg::OFS_STATUS, 32'hF, 1'b0, 32'h3);
    repeat (12 * T) @(posedge clk);
    rd(rsic_pkg::OFS_STATUS, 32'h3EF, 1'b0, 32'h264);
    wr(rsic_pkg::OFS_STATE_CMD, 32'(rsic_pkg::CMD_RX));
    repeat (330 * T) @(posedge clk);
    rd(rsic_pkg::OFS_STATUS, 32'h3EF, 1'b0, 32'h3E6);
    wr(rsic_pkg::OFS_STATE_CMD, 32'(rsic_pkg::CMD_NVM));
    wr(rsic_pkg::OFS_STATE_CMD, 32'h3);
    rd(rsic_pkg::OFS_STATUS, 32'hF, 1'b0, 32'h6);
    wr(rsic_pkg::OFS_IRQ_EN, 32'hFF);
    wr(rsic_pkg::OFS_IRQ_SEL, 32'h82);
    wr(rsic_pkg::OFS_GPO_SEL, 32'h22);
    event_src <= 8'h04;
    repeat (4) @(posedge clk);
    `CHK(general_out_two, 1'b1)
    rd(rsic_pkg::OFS_IRQ_FLAGS, 32'hFF, 1'b0, 32'h4);
    wr(rsic_pkg::OFS_IRQ_CLR, 32'h4);
    rd(rsic_pkg::OFS_IRQ_FLAGS, 32'hFF, 1'b0, 32'h0);
    event_src <= 8'h00;
    @(posedge clk);
    apb(1'b1, rsic_pkg::OFS_IRQ_CLR, 32'h4, 8'h04);
    rd(rsic_pkg::OFS_IRQ_FLAGS, 32'hFF, 1'b0, 32'h4);
    wr(rsic_pkg::OFS_IRQ_EN, 32'h0);
    rd(rsic_pkg::OFS_IRQ_FLAGS, 32'hFF, 1'b0, 32'h0);
    seed = lfsr(seed);
    live_src <= seed[5:0];
    repeat (4) @(posedge clk);
    `CHK(general_out_one, seed[0])
    `CHK(general_out_three, seed[0])
    rd(rsic_pkg::OFS_IRQ_FLAGS, 32'h3F00, 1'b0, {18'h0, seed[5:0], 8'h0});
    frame_on <= 1'b1;
    repeat (8) begin
      @(negedge recovered_clock);
      repeat (8) @(posedge clk);
      `CHK(general_out_four, demod_data)
    end
    frame_on <= 1'b0;
    wr(rsic_pkg::OFS_STATE_CMD, 32'(rsic_pkg::CMD_SLEEP));
    rd(rsic_pkg::OFS_STATUS, 32'h3EF, 1'b0, 32'h3);
    wr(rsic_pkg::OFS_RESTART, 32'h1);
    rd(rsic_pkg::OFS_STATUS, 32'hF, 1'b0, 32'h1);
    repeat (9050 * T) @(posedge clk);
    rd(rsic_pkg::OFS_STATUS, 32'hF, 1'b0, 32'h3);
    rd(rsic_pkg::OFS_XTAL_SETTLE, 32'hFFFF, 1'b0, 32'hA);
    wr(rsic_pkg::OFS_IRQ_EN, 32'h40);
    wr(rsic_pkg::OFS_SLEEP_TMR, 32'h00010001);
    repeat (1100 * T) @(posedge clk);
    rd(rsic_pkg::OFS_STATUS, 32'hF, 1'b0, 32'h4);
    rd(rsic_pkg::OFS_IRQ_FLAGS, 32'h40, 1'b0, 32'h40);
    end_of_test();
  end
endmodule : tb
